// File: design/sfcd_device.sv
// device end: command decoder clocked by the link serial clock
// Notes on behaviour
// - F5h in quad mode returns to single wire
// - 0Bh: three address bytes, eight dummies, stream
// - 0Bh in quad mode: four dummy clocks
// - dual phases: two bits per clock
// - dual pairs: msb on data line one
// - field lengths count clocks, not bits
// - 02h: address then data, program page
// - 20h: address then erase sector
// - D8h: address then erase 64K block
// - 35h in single wire enters quad mode
// - sample on rising, shift on falling
// - program/erase/mode need cs rise on byte boundary
`timescale 1ns/10ps
module sfcd_device
    import sfcd_pkg::*;
(
    // link
    sfcd_if.dev lnk,
    // user side, clk domain
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] rd_data,
    output logic [23:0] op_addr,
    output sfcd_pkg::sfcd_act_t op_kind,
    output logic op_valid,
    output logic [7:0] wr_data,
    output logic wr_valid,
    output logic quad_mode
);
    import sfcd_pkg::*;
    typedef enum {SFCD_S_OPC, SFCD_S_ADDR, SFCD_S_DUMMY, SFCD_S_RDATA, SFCD_S_WDATA, SFCD_S_WAIT, SFCD_S_IDLE} sfcd_st_t;
    sfcd_st_t st_q;
    logic quad_q;
    logic [7:0] sh_q;
    logic [2:0] bit_q;
    logic [1:0] abyte_q;
    logic [3:0] dcnt_q;
    logic [7:0] op_q;
    logic [23:0] addr_q;
    logic dual_q;
    logic [7:0] out_q;
    logic [3:0] oe_q;
    logic [3:0] dout_q;
    logic evt_tgl_q;
    logic [7:0] wbyte_q;
    logic wtgl_q;
    sfcd_act_t kind_q;
    logic [7:0] rd_s1_q, rd_s2_q;
    logic [2:0] bits_step;
    logic [7:0] sh_next;
    logic [2:0] bit_next;
    logic byte_done;
    logic [7:0] rd_cur;

    // bits per clock: 4 in quad mode, 2 in dual phases, else 1
    always_comb begin
        bits_step = quad_q ? 3'h4 : (dual_q && st_q != SFCD_S_OPC ? 3'h2 : 3'h1);
        if (quad_q) begin
            sh_next = {sh_q[3:0], lnk.io};
        end else if (dual_q && st_q != SFCD_S_OPC) begin
            sh_next = {sh_q[5:0], lnk.io[1], lnk.io[0]};
        end else begin
            sh_next = {sh_q[6:0], lnk.io[0]};
        end
        bit_next = bit_q + bits_step;
        byte_done = (bit_next == 3'h0);
        rd_cur = (bit_q == 3'h0) ? rd_s2_q : out_q;
    end

    // read data from the user side is a settled level, so two stages suffice
    always_ff @(posedge lnk.sclk) begin
        rd_s1_q <= rd_data;
        rd_s2_q <= rd_s1_q;
    end

    // rising edge: input sampling and phase sequencing
    always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
        if (lnk.cs_n) begin
            st_q <= SFCD_S_OPC;
            bit_q <= 3'h0;
            abyte_q <= 2'h0;
            dcnt_q <= 4'h0;
            dual_q <= 1'b0;
            sh_q <= 8'h00;
        end else begin
            sh_q <= sh_next;
            bit_q <= bit_next;
            case (st_q)
                SFCD_S_OPC: begin
                    if (byte_done) begin
                        op_q <= sh_next;
                        abyte_q <= 2'h0;
                        case (sh_next)
                            SFCD_OP_QUICK_READ, SFCD_OP_PAGE_PROGRAM, SFCD_OP_SECTOR_ERASE, SFCD_OP_BLOCK_ERASE:
                                st_q <= SFCD_S_ADDR;
                            SFCD_OP_DUAL_IO_READ: begin
                                st_q <= quad_q ? SFCD_S_IDLE : SFCD_S_ADDR;
                                dual_q <= 1'b1;
                            end
                            SFCD_OP_QUAD_ENTER: st_q <= quad_q ? SFCD_S_IDLE : SFCD_S_WAIT;
                            SFCD_OP_QUAD_EXIT: st_q <= quad_q ? SFCD_S_WAIT : SFCD_S_IDLE;
                            default: st_q <= SFCD_S_IDLE;
                        endcase
                    end
                end
                SFCD_S_ADDR: begin
                    if (byte_done) begin
                        addr_q <= {addr_q[15:0], sh_next};
                        abyte_q <= abyte_q + 2'h1;
                        if (abyte_q == 2'(SFCD_ADDR_BYTES - 1)) begin
                            dcnt_q <= 4'h0;
                            if (op_q == SFCD_OP_QUICK_READ || op_q == SFCD_OP_DUAL_IO_READ) begin
                                st_q <= SFCD_S_DUMMY;
                            end else if (op_q == SFCD_OP_PAGE_PROGRAM) begin
                                st_q <= SFCD_S_WDATA;
                            end else begin
                                st_q <= SFCD_S_WAIT;
                            end
                        end
                    end
                end
                SFCD_S_DUMMY: begin
                    bit_q <= 3'h0;
                    dcnt_q <= dcnt_q + 4'h1;
                    if (dcnt_q + 4'h1 == (dual_q ? SFCD_DUMMY_DUAL : (quad_q ? SFCD_DUMMY_QUAD : SFCD_DUMMY_SINGLE))) begin
                        st_q <= SFCD_S_RDATA;
                    end
                end
                SFCD_S_WDATA: ;
                SFCD_S_RDATA: ;
                SFCD_S_WAIT: begin
                    // any clock past the last byte breaks the boundary
                    st_q <= SFCD_S_IDLE;
                end
                SFCD_S_IDLE: ;
                default: st_q <= SFCD_S_IDLE;
            endcase
        end
    end

    // program bytes cross by toggle; sclk stops between frames, so the user reset clears link state directly
    always_ff @(posedge lnk.sclk or negedge rst_n) begin
        if (!rst_n) begin
            wtgl_q <= 1'b0;
            wbyte_q <= 8'h00;
        end else if (st_q == SFCD_S_WDATA && byte_done) begin
            wbyte_q <= sh_next;
            wtgl_q <= ~wtgl_q;
        end
    end

    // cs rise ends the frame; accepted commands fire only on a byte boundary
    always_ff @(posedge lnk.cs_n or negedge rst_n) begin
        if (!rst_n) begin
            evt_tgl_q <= 1'b0;
            kind_q <= SFCD_ACT_NONE;
        end else if ((st_q == SFCD_S_WAIT || st_q == SFCD_S_WDATA) && bit_q == 3'h0) begin
            evt_tgl_q <= ~evt_tgl_q;
            case (op_q)
                SFCD_OP_PAGE_PROGRAM: kind_q <= SFCD_ACT_PROGRAM;
                SFCD_OP_SECTOR_ERASE: kind_q <= SFCD_ACT_SECTOR;
                SFCD_OP_BLOCK_ERASE: kind_q <= SFCD_ACT_BLOCK;
                SFCD_OP_QUAD_ENTER: kind_q <= SFCD_ACT_QENTER;
                SFCD_OP_QUAD_EXIT: kind_q <= SFCD_ACT_QEXIT;
                default: kind_q <= SFCD_ACT_NONE;
            endcase
        end
    end

    // mode follows the accepted mode commands at the frame end
    always_ff @(posedge lnk.cs_n or negedge rst_n) begin
        if (!rst_n) begin
            quad_q <= 1'b0;
        end else if (st_q == SFCD_S_WAIT && bit_q == 3'h0 && op_q == SFCD_OP_QUAD_ENTER) begin
            quad_q <= 1'b1;
        end else if (st_q == SFCD_S_WAIT && bit_q == 3'h0 && op_q == SFCD_OP_QUAD_EXIT) begin
            quad_q <= 1'b0;
        end
    end

    // falling edge: output shifting
    always_ff @(negedge lnk.sclk or posedge lnk.cs_n) begin
        if (lnk.cs_n) begin
            oe_q <= 4'h0;
            dout_q <= 4'h0;
            out_q <= 8'h00;
        end else if (st_q == SFCD_S_RDATA) begin
            if (quad_q) begin
                dout_q <= rd_cur[7:4];
                oe_q <= 4'hF;
                out_q <= {rd_cur[3:0], 4'h0};
            end else if (dual_q) begin
                dout_q <= {2'h0, rd_cur[7:6]};
                oe_q <= 4'h3;
                out_q <= {rd_cur[5:0], 2'h0};
            end else begin
                dout_q <= {2'h0, rd_cur[7], 1'b0};
                oe_q <= 4'h2;
                out_q <= {rd_cur[6:0], 1'b0};
            end
        end else begin
            oe_q <= 4'h0;
        end
    end
    assign lnk.io_dev_o = dout_q;
    assign lnk.io_dev_oe = oe_q;

    // read address is held, not advanced per byte; exported with the event or a program byte in clk domain
    logic [2:0] ev_s_q;
    logic [2:0] w_s_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ev_s_q <= 3'h0;
            w_s_q <= 3'h0;
            op_valid <= 1'b0;
            wr_valid <= 1'b0;
            op_kind <= SFCD_ACT_NONE;
            op_addr <= 24'h000000;
            wr_data <= 8'h00;
            quad_mode <= 1'b0;
        end else begin
            ev_s_q <= {ev_s_q[1:0], evt_tgl_q};
            w_s_q <= {w_s_q[1:0], wtgl_q};
            op_valid <= ev_s_q[2] ^ ev_s_q[1];
            wr_valid <= w_s_q[2] ^ w_s_q[1];
            if (ev_s_q[2] ^ ev_s_q[1]) begin
                op_kind <= kind_q;
                op_addr <= addr_q;
                quad_mode <= quad_q;
            end
            if (w_s_q[2] ^ w_s_q[1]) begin
                wr_data <= wbyte_q;
                op_addr <= addr_q;
            end
        end
    end
endmodule

// File: design/sfcd_host.sv
// host end: issues commands, drives chip select and a divided serial clock
`timescale 1ns/10ps
module sfcd_host
    import sfcd_pkg::*;
(
    // link
    sfcd_if.host lnk,
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command request
    input wire logic req_valid,
    input wire sfcd_pkg::sfcd_cmd_t req_cmd,
    input wire logic [7:0] req_op,
    input wire logic [23:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic [7:0] req_len,
    output logic req_ready,
    // read answer and quad mode
    output logic [7:0] rsp_data,
    output logic rsp_valid,
    output logic quad_mode
);
    import sfcd_pkg::*;
    typedef enum {SFCD_H_IDLE, SFCD_H_SHIFT, SFCD_H_DESEL} sfcd_hst_t;
    sfcd_hst_t st_q;
    sfcd_cmd_t cmd_q;
    logic [3:0] div_q;
    logic sclk_q, cs_n_q;
    logic [63:0] tx_q;
    logic [7:0] nclk_q, rx_start_q, clk_idx_q;
    logic [7:0] rx_q;
    logic [2:0] rx_bits_q;
    logic dual_q, quad_q;
    logic [3:0] o_q, oe_q;
    logic [7:0] op;
    logic [7:0] n_cmd, n_addr, n_dum, n_data;
    logic [1:0] w;

    always_comb begin
        case (req_cmd)
            SFCD_CMD_READ: op = SFCD_OP_QUICK_READ;
            SFCD_CMD_DUAL_READ: op = SFCD_OP_DUAL_IO_READ;
            SFCD_CMD_PROGRAM: op = SFCD_OP_PAGE_PROGRAM;
            SFCD_CMD_SECTOR: op = SFCD_OP_SECTOR_ERASE;
            SFCD_CMD_BLOCK: op = SFCD_OP_BLOCK_ERASE;
            SFCD_CMD_QENTER: op = SFCD_OP_QUAD_ENTER;
            SFCD_CMD_QEXIT: op = SFCD_OP_QUAD_EXIT;
            default: op = req_op;
        endcase
        n_cmd = quad_q ? 8'h02 : 8'h08;
        n_addr = 8'h00;
        n_dum = 8'h00;
        n_data = 8'h00;
        if (req_cmd == SFCD_CMD_READ || req_cmd == SFCD_CMD_PROGRAM || req_cmd == SFCD_CMD_SECTOR ||
            req_cmd == SFCD_CMD_BLOCK) begin
            n_addr = quad_q ? 8'h06 : 8'h18;
        end
        if (req_cmd == SFCD_CMD_DUAL_READ) begin
            n_addr = 8'h0C;
            n_dum = {4'h0, SFCD_DUMMY_DUAL};
        end
        if (req_cmd == SFCD_CMD_READ) begin
            n_dum = {4'h0, quad_q ? SFCD_DUMMY_QUAD : SFCD_DUMMY_SINGLE};
        end
        if (req_cmd == SFCD_CMD_PROGRAM) begin
            n_data = quad_q ? 8'h02 : 8'h08;
        end
        if (req_cmd == SFCD_CMD_READ || req_cmd == SFCD_CMD_DUAL_READ) begin
            n_data = 8'(req_len * (quad_q ? 8'h02 : (req_cmd == SFCD_CMD_DUAL_READ ? 8'h04 : 8'h08)));
        end
        w = quad_q ? 2'h2 : (dual_q ? 2'h1 : 2'h0);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= SFCD_H_IDLE;
            div_q <= 4'h0;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            quad_q <= 1'b0;
            quad_mode <= 1'b0;
            cmd_q <= SFCD_CMD_READ;
            dual_q <= 1'b0;
            tx_q <= 64'h0;
            nclk_q <= 8'h00;
            rx_start_q <= 8'h00;
            clk_idx_q <= 8'h00;
            rx_q <= 8'h00;
            rx_bits_q <= 3'h0;
            o_q <= 4'h0;
            oe_q <= 4'h0;
        end else begin
            rsp_valid <= 1'b0;
            quad_mode <= quad_q;
            case (st_q)
                SFCD_H_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        cmd_q <= req_cmd;
                        // first bit stands with chip select, ahead of the first rise
                        o_q <= quad_q ? op[7:4] : {3'h0, op[7]};
                        oe_q <= quad_q ? 4'hF : 4'h1;
                        tx_q <= quad_q ? {op[3:0], req_addr, req_wdata, 28'h0} :
                            {op[6:0], req_addr, req_wdata, 25'h0};
                        nclk_q <= n_cmd + n_addr + n_dum + n_data;
                        rx_start_q <= n_cmd + n_addr + n_dum;
                        clk_idx_q <= 8'h00;
                        dual_q <= 1'b0;
                        cs_n_q <= 1'b0;
                        div_q <= 4'h0;
                        rx_bits_q <= 3'h0;
                        st_q <= SFCD_H_SHIFT;
                    end
                end
                SFCD_H_SHIFT: begin
                    div_q <= div_q + 4'h1;
                    if (div_q == SFCD_CLK_DIV) begin
                        div_q <= 4'h0;
                        if (!sclk_q) begin
                            // rising half: end the frame, or raise sclk and take read data
                            if (clk_idx_q == nclk_q) begin
                                cs_n_q <= 1'b1;
                                oe_q <= 4'h0;
                                div_q <= 4'h0;
                                // mode follows a command only once its whole frame has gone out
                                if (cmd_q == SFCD_CMD_QENTER) quad_q <= 1'b1;
                                if (cmd_q == SFCD_CMD_QEXIT) quad_q <= 1'b0;
                                st_q <= SFCD_H_DESEL;
                            end else begin
                                sclk_q <= 1'b1;
                                clk_idx_q <= clk_idx_q + 8'h01;
                                if (clk_idx_q + 8'h01 == n_cmd && cmd_q == SFCD_CMD_DUAL_READ) dual_q <= 1'b1;
                                if (clk_idx_q >= rx_start_q) begin
                                    if (cmd_q == SFCD_CMD_READ || cmd_q == SFCD_CMD_DUAL_READ) begin
                                        rx_q <= quad_q ? {rx_q[3:0], lnk.io} :
                                            (dual_q ? {rx_q[5:0], lnk.io[1], lnk.io[0]} : {rx_q[6:0], lnk.io[1]});
                                        rx_bits_q <= rx_bits_q + (3'h1 << w);
                                        if (3'(rx_bits_q + (3'h1 << w)) == 3'h0) begin
                                            rsp_valid <= 1'b1;
                                            rsp_data <= quad_q ? {rx_q[3:0], lnk.io} :
                                                (dual_q ? {rx_q[5:0], lnk.io[1], lnk.io[0]} : {rx_q[6:0], lnk.io[1]});
                                        end
                                    end
                                end
                            end
                        end else begin
                            sclk_q <= 1'b0;
                            // next bits go out on the fall, half a period before the device samples
                            if (clk_idx_q < rx_start_q || cmd_q == SFCD_CMD_PROGRAM) begin
                                if (quad_q) begin
                                    oe_q <= 4'hF;
                                    o_q <= tx_q[63:60];
                                    tx_q <= {tx_q[59:0], 4'h0};
                                end else if (dual_q) begin
                                    oe_q <= 4'h3;
                                    o_q <= {2'h0, tx_q[63:62]};
                                    tx_q <= {tx_q[61:0], 2'h0};
                                end else begin
                                    oe_q <= 4'h1;
                                    o_q <= {3'h0, tx_q[63]};
                                    tx_q <= {tx_q[62:0], 1'b0};
                                end
                            end else begin
                                oe_q <= 4'h0;
                            end
                        end
                    end
                end
                SFCD_H_DESEL: begin
                    div_q <= div_q + 4'h1;
                    if (div_q == SFCD_DESEL_CYC) st_q <= SFCD_H_IDLE;
                end
                default: st_q <= SFCD_H_IDLE;
            endcase
        end
    end
    assign lnk.sclk = sclk_q;
    assign lnk.cs_n = cs_n_q;
    assign lnk.io_host_o = o_q;
    assign lnk.io_host_oe = oe_q;
endmodule

// File: design/sfcd_if.sv
// interface: serial flash link pins between host and device
`timescale 1ns/10ps
interface sfcd_if;
    logic sclk;
    logic cs_n;
    logic [3:0] io_host_o;
    logic [3:0] io_host_oe;
    logic [3:0] io_dev_o;
    logic [3:0] io_dev_oe;
    logic [3:0] io;
    // resolved line level; undriven lines read high as if pulled up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io[i] = io_host_oe[i] ? io_host_o[i] : (io_dev_oe[i] ? io_dev_o[i] : 1'b1);
        end
    end
    modport host (output sclk, output cs_n, output io_host_o, output io_host_oe, input io);
    modport dev (input sclk, input cs_n, output io_dev_o, output io_dev_oe, input io);
endinterface

// File: design/sfcd_pkg.sv
// package: opcodes, phase lengths and timing for the serial flash command decoder
package sfcd_pkg;
    localparam logic [7:0] SFCD_OP_QUICK_READ = 8'h0B;
    localparam logic [7:0] SFCD_OP_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] SFCD_OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] SFCD_OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] SFCD_OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] SFCD_OP_QUAD_ENTER = 8'h35;
    localparam logic [7:0] SFCD_OP_QUAD_EXIT = 8'hF5;
    localparam int SFCD_ADDR_BYTES = 3;
    localparam logic [3:0] SFCD_DUMMY_SINGLE = 4'h8;
    localparam logic [3:0] SFCD_DUMMY_QUAD = 4'h4;
    localparam logic [3:0] SFCD_DUMMY_DUAL = 4'h4;
    localparam logic [2:0] SFCD_BIT_LAST = 3'h7;
    localparam logic [3:0] SFCD_CLK_DIV = 4'h1;
    localparam logic [3:0] SFCD_DESEL_CYC = 4'h4;
    typedef enum logic [2:0] {
        SFCD_ACT_NONE, SFCD_ACT_PROGRAM, SFCD_ACT_SECTOR, SFCD_ACT_BLOCK, SFCD_ACT_QENTER, SFCD_ACT_QEXIT
    } sfcd_act_t;
    // host command kinds
    typedef enum logic [2:0] {
        SFCD_CMD_READ, SFCD_CMD_DUAL_READ, SFCD_CMD_PROGRAM, SFCD_CMD_SECTOR, SFCD_CMD_BLOCK,
        SFCD_CMD_QENTER, SFCD_CMD_QEXIT, SFCD_CMD_RAW
    } sfcd_cmd_t;
endpackage

// File: test/serial_flash_array_command_decoder_tb.sv
// testbench: host and device ends joined over the link, random and corner commands
`timescale 1ns/10ps
module serial_flash_array_command_decoder_tb;
    import sfcd_pkg::*;
    logic clk;
    logic rst_n;
    logic req_valid;
    sfcd_cmd_t req_cmd;
    logic [7:0] req_op;
    logic [23:0] req_addr;
    logic [7:0] req_wdata;
    logic [7:0] req_len;
    logic req_ready;
    logic [7:0] rsp_data;
    logic rsp_valid;
    logic host_quad;
    logic [7:0] rd_data;
    logic [23:0] op_addr;
    sfcd_act_t op_kind;
    logic op_valid;
    logic [7:0] wr_data;
    logic wr_valid;
    logic dev_quad;
    int n_fail;
    int checked;
    int seed;
    int n_op;
    logic dev_drove;
    logic exp_quad;
    sfcd_act_t got_kind;
    logic [23:0] got_addr;
    logic [7:0] rq[$];
    logic [7:0] wq[$];
    sfcd_cmd_t kinds[5] = '{SFCD_CMD_READ, SFCD_CMD_PROGRAM, SFCD_CMD_SECTOR, SFCD_CMD_BLOCK, SFCD_CMD_DUAL_READ};

    sfcd_if lnk();
    sfcd_host i_sfcd_host(.lnk(lnk), .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_len(req_len), .req_ready(req_ready),
        .rsp_data(rsp_data), .rsp_valid(rsp_valid), .quad_mode(host_quad));
    sfcd_device i_sfcd_device(.lnk(lnk), .clk(clk), .rst_n(rst_n), .rd_data(rd_data), .op_addr(op_addr),
        .op_kind(op_kind), .op_valid(op_valid), .wr_data(wr_data), .wr_valid(wr_valid), .quad_mode(dev_quad));
    sfcd_link_assertions i_sfcd_link_assertions(.clk(clk), .rst_n(rst_n), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
        .io_host_o(lnk.io_host_o), .io_host_oe(lnk.io_host_oe), .io_dev_o(lnk.io_dev_o),
        .io_dev_oe(lnk.io_dev_oe));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // collect what both user sides report during a frame
    always @(posedge clk) begin
        if (rst_n) begin
            if (rsp_valid === 1'b1) rq.push_back(rsp_data);
            if (wr_valid === 1'b1) wq.push_back(wr_data);
            if (op_valid === 1'b1) begin
                n_op++;
                got_kind = op_kind;
                got_addr = op_addr;
            end
            if (lnk.io_dev_oe !== 4'h0) dev_drove = 1'b1;
        end
    end

    task automatic end_sim;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_v(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic chk_k(input sfcd_act_t got, input sfcd_act_t exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    function automatic sfcd_act_t exp_act(input sfcd_cmd_t c, input logic q);
        case (c)
            SFCD_CMD_PROGRAM: return SFCD_ACT_PROGRAM;
            SFCD_CMD_SECTOR: return SFCD_ACT_SECTOR;
            SFCD_CMD_BLOCK: return SFCD_ACT_BLOCK;
            SFCD_CMD_QENTER: return q ? SFCD_ACT_NONE : SFCD_ACT_QENTER;
            SFCD_CMD_QEXIT: return q ? SFCD_ACT_QEXIT : SFCD_ACT_NONE;
            default: return SFCD_ACT_NONE;
        endcase
    endfunction

    // a hang counts as a mismatch and closes the run
    task automatic wait_for(input bit idle);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!(req_ready === 1'b1 && (!idle || lnk.cs_n === 1'b1)) && k < 5000);
        if (k >= 5000) begin
            n_fail++;
            end_sim;
        end
    endtask

    task automatic run(input sfcd_cmd_t c, input logic [7:0] op, input logic [23:0] addr);
        sfcd_act_t ek;
        ek = exp_act(c, exp_quad);
        rq.delete();
        wq.delete();
        n_op = 0;
        dev_drove = 1'b0;
        got_kind = SFCD_ACT_NONE;
        @(negedge clk);
        rd_data = 8'($random(seed));
        req_cmd = c;
        req_op = op;
        req_addr = addr;
        req_wdata = 8'($random(seed));
        req_len = 8'(1 + {$random(seed)} % 4);
        req_valid = 1'b1;
        wait_for(1'b0);
        @(negedge clk);
        req_valid = 1'b0;
        wait_for(1'b1);
        // the device reports a few cycles after chip select rises
        repeat (10) @(posedge clk);
        if (ek == SFCD_ACT_QENTER) exp_quad = 1'b1;
        if (ek == SFCD_ACT_QEXIT) exp_quad = 1'b0;
        case (c)
            SFCD_CMD_PROGRAM: begin
                chk_k(got_kind, ek);
                chk_v(got_addr, addr);
                chk_v(24'(wq.size()), 24'h000001);
                chk_v(24'(wq[0]), 24'(req_wdata));
            end
            SFCD_CMD_SECTOR: begin
                chk_k(got_kind, ek);
                chk_v(got_addr, addr);
            end
            SFCD_CMD_BLOCK: begin
                chk_k(got_kind, ek);
                chk_v(got_addr, addr);
            end
            SFCD_CMD_READ, SFCD_CMD_DUAL_READ: begin
                chk_v(24'(rq.size()), 24'(req_len));
                foreach (rq[i]) chk_v(24'(rq[i]), 24'(rd_data));
            end
            SFCD_CMD_QENTER, SFCD_CMD_QEXIT: begin
                chk_k(got_kind, ek);
                chk_v(24'(dev_quad), 24'(exp_quad));
                chk_v(24'(host_quad), 24'(exp_quad));
            end
            default: begin
                chk_v(24'(n_op), 24'h000000);
                chk_v(24'(dev_drove), 24'h000000);
                chk_v(24'(dev_quad), 24'(exp_quad));
            end
        endcase
        $display("test cmd %0d op %0h quad %0b done", c, op, exp_quad);
    endtask

    initial begin
        seed = 32'hd1a6ad1b;
        n_fail = 0;
        checked = 0;
        exp_quad = 1'b0;
        rst_n = 1'b1;
        req_valid = 1'b0;
        req_cmd = SFCD_CMD_READ;
        req_op = 8'h00;
        req_addr = 24'h000000;
        req_wdata = 8'h00;
        req_len = 8'h01;
        rd_data = 8'h00;
        // a real falling edge clears the device's link-side state, whose clock is idle in reset
        #1;
        rst_n = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        // enter and leave quad mode first, starting from the single-wire mode that reset loads
        run(SFCD_CMD_QENTER, 8'h00, 24'h000000);
        run(SFCD_CMD_QEXIT, 8'h00, 24'h000000);
        run(SFCD_CMD_RAW, SFCD_OP_QUAD_EXIT, 24'h000000);
        run(SFCD_CMD_RAW, 8'h9F, 24'h000000);
        run(SFCD_CMD_READ, 8'h00, 24'hFFFFFF);
        run(SFCD_CMD_DUAL_READ, 8'h00, 24'h000000);
        for (int i = 0; i < 12; i++) run(kinds[{$random(seed)} % 5], 8'h00, 24'($random(seed)));
        run(SFCD_CMD_QENTER, 8'h00, 24'h000000);
        run(SFCD_CMD_READ, 8'h00, 24'hFFFFFF);
        for (int i = 0; i < 8; i++) run(kinds[{$random(seed)} % 4], 8'h00, 24'($random(seed)));
        run(SFCD_CMD_RAW, SFCD_OP_QUAD_ENTER, 24'h000000);
        run(SFCD_CMD_QEXIT, 8'h00, 24'h000000);
        run(SFCD_CMD_READ, 8'h00, 24'h123456);
        end_sim;
    end
endmodule

// File: test/sfcd_link_assertions.sv
// checker: link-level timing and framing between the host and device ends
`timescale 1ns/10ps
module sfcd_link_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_host_o,
    input wire logic [3:0] io_host_oe,
    input wire logic [3:0] io_dev_o,
    input wire logic [3:0] io_dev_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [15:0] rise_cnt_q;

    // rising serial edges seen in the current frame; cleared while deselected
    always_ff @(posedge clk) begin
        if (!rst_n || cs_n) begin
            rise_cnt_q <= 16'h0000;
        end else if ($rose(sclk)) begin
            rise_cnt_q <= rise_cnt_q + 16'h0001;
        end
    end

    a_float_when_idle: assert property (cs_n && $past(cs_n) |-> io_dev_oe == 4'h0)
        else $error("device drives the link while deselected");
    a_no_line_clash: assert property ((io_host_oe & io_dev_oe) == 4'h0)
        else $error("host and device drive one line together");
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("serial clock not low while deselected");
    a_sclk_high_phase: assert property ($rose(sclk) |-> sclk [*2] ##1 !sclk)
        else $error("serial clock high phase not two cycles");
    a_deselect_gap: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("chip select high for fewer than four cycles");
    a_host_shift_fall: assert property (!cs_n && $past(!cs_n) && $changed(io_host_o) |-> $fell(sclk))
        else $error("host data changed off the falling serial edge");
    a_dev_hold_rise: assert property ($rose(sclk) |-> $stable(io_dev_o & io_dev_oe))
        else $error("device data changed at a rising serial edge");
    a_frame_whole: assert property ($rose(cs_n) |-> rise_cnt_q[0] == 1'b0 && rise_cnt_q != 16'h0000)
        else $error("frame ended off a whole clock pair");
endmodule
